// ### kbhw_pkg.sv
// Constants, register map and state types of the A20 gate / keyboard reset assist.
// Assumes a 10 MHz system clock and an 8-bit register port.
package kbhw_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] ADDR_DATA = 8'h60;
    localparam logic [7:0] ADDR_CMD = 8'h64;
    localparam logic [7:0] ADDR_FAST = 8'h92;
    localparam logic [7:0] ADDR_CTRL = 8'hF0;

    // ****************************************
    // Fields and reset values
    // ****************************************
    localparam logic [7:0] CTRL_RESET = 8'h80;
    localparam logic [7:0] CTRL_RW_MASK = 8'hC7;
    localparam logic [7:0] FAST_RESET = 8'h24;
    localparam logic [7:0] FAST_FIXED = 8'h24;
    localparam int CTRL_CLK_HI = 7;
    localparam int CTRL_CLK_LO = 6;
    localparam int CTRL_FAST_EN = 2;
    localparam int CTRL_HW_GATE = 1;
    localparam int CTRL_HW_RST = 0;
    localparam logic [1:0] CLK_SEL_12M = 2'b10;
    localparam int FAST_GATE_BIT = 1;
    localparam int FAST_RST_BIT = 0;
    localparam int D1_GATE_BIT = 1;
    localparam int D1_RST_BIT = 0;
    localparam logic [7:0] CMD_D1 = 8'hD1;
    localparam logic [7:0] CMD_PULSE = 8'hFE;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_KHZ = 10000;
    localparam int DELAY_NS = 14000;
    localparam int LOW_NS = 6000;
    localparam logic [7:0] DELAY_CYC = 8'((DELAY_NS * CLK_KHZ + 999999) / 1000000);
    localparam logic [7:0] LOW_CYC = 8'((LOW_NS * CLK_KHZ + 999999) / 1000000);

    // ****************************************
    // State types
    // ****************************************
    typedef enum logic [1:0] {KBHW_P_IDLE = 2'b00, KBHW_P_DELAY = 2'b01,
        KBHW_P_LOW = 2'b11} kbhw_pulse_t;
    typedef enum logic {KBHW_C_IDLE = 1'b0, KBHW_C_WAIT = 1'b1} kbhw_cmd_t;

endpackage : kbhw_pkg

// ### kbhw_pulse_gen.sv
// Delayed keyboard reset pulse: waits, then holds a low request for a fixed time.
// Assumes start is a one-cycle strobe from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module kbhw_pulse_gen
    import kbhw_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // Control
    input wire logic start,
    output logic pulseLow
);

    kbhw_pulse_t state_reg;
    kbhw_pulse_t state_next;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic pulseLow_next;

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            KBHW_P_IDLE:
            begin
                if (start)
                begin
                    state_next = KBHW_P_DELAY;
                    cnt_next = 8'h00;
                end
            end
            KBHW_P_DELAY:
            begin
                cnt_next = cnt_reg + 8'h01;
                if (cnt_reg == DELAY_CYC - 8'h01)
                begin
                    state_next = KBHW_P_LOW;
                    cnt_next = 8'h00;
                end
            end
            KBHW_P_LOW:
            begin
                cnt_next = cnt_reg + 8'h01;
                if (cnt_reg == LOW_CYC - 8'h01)
                begin
                    state_next = KBHW_P_IDLE;
                    cnt_next = 8'h00;
                end
            end
            default:
            begin
                state_next = KBHW_P_IDLE;
                cnt_next = 8'h00;
            end
        endcase
        pulseLow_next = (state_next == KBHW_P_LOW);
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= KBHW_P_IDLE;
            cnt_reg <= 8'h00;
            pulseLow <= 1'b0;
        end
        else if (ce)
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            pulseLow <= pulseLow_next;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_pulse_start;
        @(posedge sys_clk) disable iff (rst)
        (ce && start && state_reg == KBHW_P_IDLE) |=> (state_reg == KBHW_P_DELAY && !pulseLow);
    endproperty
    a_pulse_start: assert property (p_pulse_start) else $error("pulse did not start delay");
    property p_pulse_low;
        @(posedge sys_clk) disable iff (rst)
        (ce && state_reg == KBHW_P_DELAY && cnt_reg == DELAY_CYC - 8'h01) |=> pulseLow;
    endproperty
    a_pulse_low: assert property (p_pulse_low) else $error("low phase missing after delay");
    property p_pulse_end;
        @(posedge sys_clk) disable iff (rst)
        (ce && state_reg == KBHW_P_LOW && cnt_reg == LOW_CYC - 8'h01) |=> !pulseLow;
    endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("low phase not ended");

endmodule : kbhw_pulse_gen
`default_nettype wire

// ### kbhw_gate_reset.sv
// A20 gate and keyboard reset assist logic with its register port.
// Assumes register port and firmware levels come from logic on sys_clk.
//
// How it works
// - Control bits 7:6 select the controller clock, and only pattern 10 (12 MHz) is valid.
// - Control bit 2 lets the fast port drive the gate and reset, and clearing it disables the port.
// - Control bit 1 hands the A20 gate output to the hardware logic.
// - Control bit 0 hands the keyboard reset output to the hardware logic.
// - The data byte after a D1 command sets the gate to its bit 1.
// - The data byte after a D1 command sets the reset output to its bit 0.
// - An FE command gives a reset low pulse of at least 6 us after at least 14 us.
// - On the controller path the gate and the reset are each owned by either firmware or the hardware logic, never both.
// - With the fast port enabled its gate and reset are merged with the controller path.
// - Fast port bit 1 drives the gate high when 1; when 0 it leaves the gate to the controller path.
// - Fast port bit 0 rising gives a reset low pulse of at least 6 us after at least 14 us.
// - The fast port resets to 0x24 with bits 5 and 2 reading 1 and 7:6, 4:3 reading 0.
//
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module kbhw_gate_reset
    import kbhw_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [7:0] regRdData,
    // Firmware levels
    input wire logic fwGateLevel,
    input wire logic fwResetN,
    // Outputs
    output logic addrLine20Gate,
    output logic cpuResetOutN,
    output logic clkSel12m
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic isWrite(input logic stb, input logic [7:0] a, input logic [7:0] t);
        isWrite = stb && (a == t);
    endfunction : isWrite

    // ****************************************
    // Declarations
    // ****************************************
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic fastGateLevel_reg;
    logic fastGateLevel_next;
    logic fastResetRequest_reg;
    logic fastResetRequest_next;
    logic hwGateLevel_reg;
    logic hwGateLevel_next;
    logic hwResetLevel_reg;
    logic hwResetLevel_next;
    kbhw_cmd_t cmd_reg;
    kbhw_cmd_t cmd_next;
    logic [7:0] rdData_next;
    logic gate_next;
    logic resetN_next;
    logic clkSel_next;
    logic ctrlWrite;
    logic fastWrite;
    logic cmdWrite;
    logic dataWrite;
    logic fastPortEnable;
    logic hwGateEnable;
    logic hwResetEnable;
    logic feStart;
    logic fastStart;
    logic fePulseLow;
    logic fastPulseLow;
    logic ctlrGate;
    logic ctlrResetAssert;
    logic fastResetAssert;

    assign ctrlWrite = isWrite(regWrStb, regAddr, ADDR_CTRL);
    assign fastWrite = isWrite(regWrStb, regAddr, ADDR_FAST);
    assign cmdWrite = isWrite(regWrStb, regAddr, ADDR_CMD);
    assign dataWrite = isWrite(regWrStb, regAddr, ADDR_DATA);
    assign fastPortEnable = ctrl_reg[CTRL_FAST_EN];
    assign hwGateEnable = ctrl_reg[CTRL_HW_GATE];
    assign hwResetEnable = ctrl_reg[CTRL_HW_RST];

    // ****************************************
    // Control register
    // ****************************************
    always_comb
    begin
        ctrl_next = ctrl_reg;
        if (ctrlWrite)
        begin
            ctrl_next = regWrData & CTRL_RW_MASK;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_reg <= CTRL_RESET;
        end
        else if (ce)
        begin
            ctrl_reg <= ctrl_next;
        end
    end

    // ****************************************
    // Fast control port
    // ****************************************
    always_comb
    begin
        fastGateLevel_next = fastGateLevel_reg;
        fastResetRequest_next = fastResetRequest_reg;
        fastStart = 1'b0;
        if (fastWrite)
        begin
            fastGateLevel_next = regWrData[FAST_GATE_BIT];
            fastResetRequest_next = regWrData[FAST_RST_BIT];
            fastStart = fastPortEnable && regWrData[FAST_RST_BIT] && !fastResetRequest_reg;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            fastGateLevel_reg <= FAST_RESET[FAST_GATE_BIT];
            fastResetRequest_reg <= FAST_RESET[FAST_RST_BIT];
        end
        else if (ce)
        begin
            fastGateLevel_reg <= fastGateLevel_next;
            fastResetRequest_reg <= fastResetRequest_next;
        end
    end

    // ****************************************
    // Command decode
    // ****************************************
    always_comb
    begin
        cmd_next = cmd_reg;
        hwGateLevel_next = hwGateLevel_reg;
        hwResetLevel_next = hwResetLevel_reg;
        feStart = 1'b0;
        case (cmd_reg)
            KBHW_C_IDLE:
            begin
                if (cmdWrite && regWrData == CMD_D1)
                begin
                    cmd_next = KBHW_C_WAIT;
                end
            end
            KBHW_C_WAIT:
            begin
                if (cmdWrite && regWrData != CMD_D1)
                begin
                    cmd_next = KBHW_C_IDLE;
                end
                else if (dataWrite)
                begin
                    cmd_next = KBHW_C_IDLE;
                    hwGateLevel_next = regWrData[D1_GATE_BIT];
                    hwResetLevel_next = regWrData[D1_RST_BIT];
                end
            end
            default:
            begin
                cmd_next = KBHW_C_IDLE;
            end
        endcase
        if (cmdWrite && regWrData == CMD_PULSE && hwResetEnable)
        begin
            feStart = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            cmd_reg <= KBHW_C_IDLE;
            hwGateLevel_reg <= 1'b0;
            hwResetLevel_reg <= 1'b1;
        end
        else if (ce)
        begin
            cmd_reg <= cmd_next;
            hwGateLevel_reg <= hwGateLevel_next;
            hwResetLevel_reg <= hwResetLevel_next;
        end
    end

    // ****************************************
    // Reset pulse timers
    // ****************************************
    kbhw_pulse_gen u_fe_pulse (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .start(feStart),
        .pulseLow(fePulseLow)
    );

    kbhw_pulse_gen u_fast_pulse (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .start(fastStart),
        .pulseLow(fastPulseLow)
    );

    // ****************************************
    // Output merge and read path
    // ****************************************
    always_comb
    begin
        ctlrGate = hwGateEnable ? hwGateLevel_reg : fwGateLevel;
        ctlrResetAssert = hwResetEnable ? (!hwResetLevel_reg || fePulseLow) : !fwResetN;
        fastResetAssert = fastPortEnable && fastPulseLow;
        gate_next = ctlrGate || (fastPortEnable && fastGateLevel_reg);
        resetN_next = !(ctlrResetAssert || fastResetAssert);
        clkSel_next = (ctrl_reg[CTRL_CLK_HI:CTRL_CLK_LO] == CLK_SEL_12M);
        rdData_next = 8'h00;
        if (regRdStb)
        begin
            case (regAddr)
                ADDR_CTRL: rdData_next = ctrl_reg;
                ADDR_FAST: rdData_next = FAST_FIXED |
                    {6'h00, fastGateLevel_reg, fastResetRequest_reg};
                default: rdData_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            regRdData <= 8'h00;
            addrLine20Gate <= 1'b0;
            cpuResetOutN <= 1'b1;
            clkSel12m <= 1'b1;
        end
        else if (ce)
        begin
            regRdData <= rdData_next;
            addrLine20Gate <= gate_next;
            cpuResetOutN <= resetN_next;
            clkSel12m <= clkSel_next;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_clk_sel;
        @(posedge sys_clk) disable iff (rst)
        ce |=> (clkSel12m == ($past(ctrl_reg[CTRL_CLK_HI:CTRL_CLK_LO]) == CLK_SEL_12M));
    endproperty
    a_clk_sel: assert property (p_clk_sel) else $error("clock select flag wrong");

    property p_fast_off;
        @(posedge sys_clk) disable iff (rst)
        (ce && !fastPortEnable && !hwGateEnable) |=> (addrLine20Gate == $past(fwGateLevel));
    endproperty
    a_fast_off: assert property (p_fast_off) else $error("disabled fast port moved gate");

    property p_hw_gate;
        @(posedge sys_clk) disable iff (rst)
        (ce && hwGateEnable && !fastPortEnable) |=> (addrLine20Gate == $past(hwGateLevel_reg));
    endproperty
    a_hw_gate: assert property (p_hw_gate) else $error("gate not from hardware logic");

    property p_fw_reset;
        @(posedge sys_clk) disable iff (rst)
        (ce && !hwResetEnable && !fastPortEnable) |=> (cpuResetOutN == $past(fwResetN));
    endproperty
    a_fw_reset: assert property (p_fw_reset) else $error("reset not from firmware");

    property p_d1_gate;
        @(posedge sys_clk) disable iff (rst)
        (ce && cmd_reg == KBHW_C_WAIT && dataWrite)
            |=> (hwGateLevel_reg == $past(regWrData[D1_GATE_BIT])) && cmd_reg == KBHW_C_IDLE;
    endproperty
    a_d1_gate: assert property (p_d1_gate) else $error("D1 data did not set gate");

    property p_d1_reset;
        @(posedge sys_clk) disable iff (rst)
        (ce && cmd_reg == KBHW_C_WAIT && dataWrite)
            |=> (hwResetLevel_reg == $past(regWrData[D1_RST_BIT]));
    endproperty
    a_d1_reset: assert property (p_d1_reset) else $error("D1 data did not set reset");

    property p_fast_gate;
        @(posedge sys_clk) disable iff (rst)
        (ce && fastWrite) |=> (fastGateLevel_reg == $past(regWrData[FAST_GATE_BIT]));
    endproperty
    a_fast_gate: assert property (p_fast_gate) else $error("fast gate bit not stored");

    property p_merge;
        @(posedge sys_clk) disable iff (rst)
        (ce && fastPortEnable && (fastGateLevel_reg || ctlrGate)) |=> addrLine20Gate;
    endproperty
    a_merge: assert property (p_merge) else $error("merged gate not OR of sources");

    property p_fast_read;
        @(posedge sys_clk) disable iff (rst)
        (ce && regRdStb && regAddr == ADDR_FAST) |=> (regRdData[7:2] == 6'b001001);
    endproperty
    a_fast_read: assert property (p_fast_read) else $error("fast port reserved bits wrong");

    property p_ctrl_read;
        @(posedge sys_clk) disable iff (rst)
        (ce && regRdStb && regAddr == ADDR_CTRL) |=> (regRdData[5:3] == 3'b000);
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control reserved bits not zero");

endmodule : kbhw_gate_reset
`default_nettype wire

// ### kbhw_host_model.sv
// Host side model: drives the register port with one-cycle strobes.
// Assumes the slave answers a read in the next cycle and never stalls.
`timescale 1ns/10ps
`default_nettype none
module kbhw_host_model
    import kbhw_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Register port
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    output logic regWrStb,
    output logic regRdStb,
    input wire logic [7:0] regRdData
);
    // ********************************
    // Bus cycles
    // ********************************
    initial
    begin
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrStb = 1'b0;
        regRdStb = 1'b0;
    end

    // Released lines show the inverse, never the last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge sys_clk);
        regWrStb <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge sys_clk);
        regRdStb <= 1'b0;
        regAddr <= ~a;
        #1;
        d = regRdData;
    endtask : rd

    task automatic fastReset(input logic [7:0] keep);
        wr(ADDR_FAST, keep & 8'hFE);
        wr(ADDR_FAST, keep | 8'h01);
    endtask : fastReset
endmodule : kbhw_host_model
`default_nettype wire

// ### kbhw_gate_reset_test.sv
// Self-checking bench for the A20 gate and keyboard reset assist.
// Assumes the host model drives the register port; bench drives the rest.
`timescale 1ns/10ps
`default_nettype none
module kbhw_gate_reset_test
    import kbhw_pkg::*;
;
    logic sys_clk, rst, ce, fwGateLevel, fwResetN;
    logic [7:0] regAddr, regWrData, regRdData, rdv;
    logic regWrStb, regRdStb, addrLine20Gate, cpuResetOutN, clkSel12m;
    int num_errors, cmp_count;

    kbhw_gate_reset i_kbhw_gate_reset (.sys_clk(sys_clk), .rst(rst), .ce(ce),
        .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
        .regRdStb(regRdStb), .regRdData(regRdData), .fwGateLevel(fwGateLevel),
        .fwResetN(fwResetN), .addrLine20Gate(addrLine20Gate),
        .cpuResetOutN(cpuResetOutN), .clkSel12m(clkSel12m));
    kbhw_host_model i_kbhw_host_model (.sys_clk(sys_clk), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData(regRdData));

    // ********************************
    // Helpers
    // ********************************
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic results();
        $display("Compares %0d, errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
        begin
            $display("Test passed");
        end
        else
        begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8

    task automatic chkBit(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask : chkBit

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_kbhw_host_model.wr(a, d);
    endtask : wr

    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        i_kbhw_host_model.rd(a, rdv);
        chk8(rdv, exp);
    endtask : rdChk

    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : settle

    task automatic setFw(input logic g, input logic r);
        @(posedge sys_clk);
        fwGateLevel <= g;
        fwResetN <= r;
    endtask : setFw

    // Counts delay and low time from the edge that samples the write strobe
    task automatic pulseChk();
        int n;
        int m;
        n = 0;
        m = 0;
        while (cpuResetOutN !== 1'b0 && n < 300)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        while (cpuResetOutN !== 1'b1 && m < 300)
        begin
            @(posedge sys_clk);
            #1;
            m++;
        end
        chk8(8'(n), DELAY_CYC + 8'h01);
        chk8(8'(m), LOW_CYC);
    endtask : pulseChk

    task automatic noPulse();
        int k;
        k = 0;
        repeat (220)
        begin
            @(posedge sys_clk);
            #1;
            if (cpuResetOutN !== 1'b1) k++;
        end
        chk8(8'(k), 8'h00);
    endtask : noPulse

    // ********************************
    // Tests
    // ********************************
    initial
    begin
        #3_000_000;
        num_errors++;
        results();
    end

    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        fwGateLevel = 1'b0;
        fwResetN = 1'b1;
        num_errors = 0;
        cmp_count = 0;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        rdChk(ADDR_CTRL, 8'h80);
        rdChk(ADDR_FAST, 8'h24);
        chkBit(clkSel12m, 1'b1);
        chkBit(cpuResetOutN, 1'b1);
        rdChk(8'h33, 8'h00);
        for (int p = 0; p < 4; p++)
        begin
            wr(ADDR_CTRL, {2'(p), 6'h3F});
            settle();
            chkBit(clkSel12m, p == 2);
            rdChk(ADDR_CTRL, {2'(p), 6'h07});
        end
        @(posedge sys_clk);
        ce <= 1'b0;
        wr(ADDR_CTRL, 8'h00);
        @(posedge sys_clk);
        ce <= 1'b1;
        rdChk(ADDR_CTRL, 8'hC7);
        wr(ADDR_CTRL, 8'h80);
        setFw(1'b1, 1'b0);
        wr(ADDR_CMD, CMD_D1);
        wr(ADDR_DATA, 8'h01);
        settle();
        chkBit(addrLine20Gate, 1'b1);
        chkBit(cpuResetOutN, 1'b0);
        wr(ADDR_CTRL, 8'h83);
        settle();
        chkBit(addrLine20Gate, 1'b0);
        chkBit(cpuResetOutN, 1'b1);
        for (int d = 0; d < 4; d++)
        begin
            wr(ADDR_CMD, CMD_D1);
            wr(ADDR_DATA, 8'(d));
            settle();
            chkBit(addrLine20Gate, d[1]);
            chkBit(cpuResetOutN, d[0]);
        end
        wr(ADDR_CMD, CMD_D1);
        wr(ADDR_CMD, 8'hAA);
        wr(ADDR_DATA, 8'h00);
        settle();
        chkBit(addrLine20Gate, 1'b1);
        wr(ADDR_CMD, CMD_PULSE);
        pulseChk();
        setFw(1'b0, 1'b1);
        wr(ADDR_CTRL, 8'h82);
        wr(ADDR_CMD, CMD_PULSE);
        noPulse();
        wr(ADDR_CTRL, 8'h04);
        wr(ADDR_FAST, 8'h02);
        settle();
        chkBit(addrLine20Gate, 1'b1);
        rdChk(ADDR_FAST, 8'h26);
        wr(ADDR_FAST, 8'h00);
        settle();
        chkBit(addrLine20Gate, 1'b0);
        setFw(1'b1, 1'b1);
        settle();
        chkBit(addrLine20Gate, 1'b1);
        setFw(1'b0, 1'b1);
        i_kbhw_host_model.fastReset(8'h00);
        pulseChk();
        rdChk(ADDR_FAST, 8'h25);
        wr(ADDR_FAST, 8'h01);
        noPulse();
        i_kbhw_host_model.fastReset(8'h00);
        pulseChk();
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_FAST, 8'h02);
        settle();
        chkBit(addrLine20Gate, 1'b0);
        i_kbhw_host_model.fastReset(8'h02);
        noPulse();
        results();
    end
endmodule : kbhw_gate_reset_test
`default_nettype wire
